// *** srps_top.sv ***
// Our own choices: the AXI4-Lite slave port and the register offsets.
`include "srps_params.svh"

module srps_top #(
  parameter int CTRL_PERIOD_CYC = `SRPS_CTRL_PERIOD_NS / `SRPS_CLK_PERIOD_NS
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire srps_pkg::srps_keys_s operator_panel,
  input  wire logic               alarm_event,
  input  wire logic               remote_run,
  input  wire logic [15:0]        remote_ref,
  input  wire logic [15:0]        fb_ain54,
  input  wire logic [15:0]        fb_ain53,
  input  wire logic [15:0]        fb_bus,
  output logic [15:0]             motor_freq,
  output logic                    motor_run,
  output logic                    remote_active,
  output logic                    alarm_active
);
  import srps_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (CTRL_PERIOD_CYC < 2) begin : g_bad_period
    $error("CTRL_PERIOD_CYC must be at least 2");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  srps_keys_s   keys_s;
  srps_keys_s   keys_prev_q;
  logic         alarm_s;
  logic         rrun_s;
  logic [15:0]  rref_s;
  logic [15:0]  ain54_s;
  logic [15:0]  ain53_s;
  logic [15:0]  fbus_s;

  // Word inputs are slow analog samples; a torn word lasts one sample
  srps_sync #(.WIDTH(8)) u_sync_bits (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({operator_panel, alarm_event, remote_run}),
    .q       ({keys_s, alarm_s, rrun_s})
  );

  srps_sync #(.WIDTH(64)) u_sync_words (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({remote_ref, fb_ain54, fb_ain53, fb_bus}),
    .q       ({rref_s, ain54_s, ain53_s, fbus_s})
  );

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  srps_ctrl_s   ctrl_q;
  srps_gain_s   gain_q;
  srps_limits_s lim_q;
  logic [15:0]  ramp_step_q;
  logic [15:0]  local_ref_q;
  srps_mode_e   mode_q;
  srps_mode_e   mode_d;
  logic         run_q;
  logic         alarm_q;
  logic         remote_q;
  logic         local_q;
  logic [31:0]  per_cnt_q;
  logic         tick_q;
  logic [15:0]  ti_cnt_q;
  logic signed [31:0] integ_q;
  logic [15:0]  ramp_q;
  logic [15:0]  speed_q;
  logic [15:0]  freq_q;

  // ----------------------------------------
  // Panel key decode
  // ----------------------------------------
  wire press_man   = keys_s.man_start  & ~keys_prev_q.man_start  & ctrl_q.man_key_en;
  wire press_auto  = keys_s.auto_start & ~keys_prev_q.auto_start & ctrl_q.auto_key_en;
  wire press_off   = keys_s.off        & ~keys_prev_q.off        & ctrl_q.off_key_en;
  wire press_reset = keys_s.reset      & ~keys_prev_q.reset      & ctrl_q.reset_key_en;
  wire press_up    = keys_s.up   & ~keys_prev_q.up;
  wire press_down  = keys_s.down & ~keys_prev_q.down;

  // Off key beats start keys pressed in the same cycle
  always_comb begin
    mode_d = mode_q;
    if (press_off) begin
      mode_d = (mode_q == SRPS_KM_MAN || mode_q == SRPS_KM_MAN_OFF)
             ? SRPS_KM_MAN_OFF : SRPS_KM_AUTO_OFF;
    end else if (press_man) begin
      mode_d = SRPS_KM_MAN;
    end else if (press_auto) begin
      mode_d = SRPS_KM_AUTO;
    end
  end

  // Site selection and run qualification
  wire auto_side  = (mode_q == SRPS_KM_AUTO) || (mode_q == SRPS_KM_AUTO_OFF);
  wire remote_d   = (ctrl_q.ref_site == `SRPS_SITE_REMOTE) ? 1'b1 :
                    (ctrl_q.ref_site == `SRPS_SITE_LOCAL)  ? 1'b0 : auto_side;
  wire run_d      = ~alarm_q & ((mode_q == SRPS_KM_MAN) |
                                ((mode_q == SRPS_KM_AUTO) & rrun_s));
  wire alarm_d    = alarm_s | (alarm_q & ~press_reset);

  // ----------------------------------------
  // PI controller (proportional and integral terms, no derivative)
  // ----------------------------------------
  wire [15:0] fb_w = (ctrl_q.fb_sel == 2'h1) ? ain53_s :
                     (ctrl_q.fb_sel == 2'h2) ? fbus_s  : ain54_s;
  wire signed [16:0] sp_m_fb = $signed({1'b0, rref_s}) - $signed({1'b0, fb_w});
  wire signed [16:0] err_w   = ctrl_q.control_direction_select
                             ? -sp_m_fb : sp_m_fb;
  wire signed [33:0] prop_w  = err_w * $signed({1'b0, gain_q.proportional_gain});
  wire signed [35:0] sum_w   = 36'(prop_w >>> `SRPS_KP_FRAC_BITS) + 36'(integ_q);
  wire        sat_lo   = sum_w < 36'sh0;
  wire        sat_hi   = sum_w > $signed({20'h0, lim_q.speed_max});
  wire [15:0] pid_out  = sat_lo ? 16'h0000 : sat_hi ? lim_q.speed_max : sum_w[15:0];
  wire        ti_off   = gain_q.integral_time == `SRPS_TI_OFF;
  wire        wind_hold = ctrl_q.integrator_hold_enable &
                          ((sat_hi & (err_w > 17'sh0)) | (sat_lo & (err_w < 17'sh0)));
  wire        ti_due   = ({1'b0, ti_cnt_q} + 17'h1) >= {1'b0, gain_q.integral_time};
  wire        closed_w = remote_q & (ctrl_q.cfg_mode == `SRPS_CFG_CLOSED);
  wire        integ_go = tick_q & closed_w & run_q & ~ti_off & ~wind_hold;

  // ----------------------------------------
  // Demand, ramp and limit chain
  // ----------------------------------------
  wire [15:0] active_ref = remote_q ? rref_s : local_ref_q;
  wire [15:0] demand_w   = ~run_q ? 16'h0000 : closed_w ? pid_out : active_ref;
  wire [16:0] ramp_up    = {1'b0, ramp_q} + {1'b0, ramp_step_q};
  wire [16:0] ramp_dn    = {1'b0, demand_w} + {1'b0, ramp_step_q};
  wire [15:0] ramp_d     = ({1'b0, demand_w} > ramp_up) ? ramp_up[15:0] :
                           (ramp_dn < {1'b0, ramp_q}) ? ramp_q - ramp_step_q : demand_w;
  wire [15:0] speed_d    = (ramp_d > lim_q.speed_max) ? lim_q.speed_max : ramp_d;
  wire [15:0] freq_d     = (speed_d > lim_q.freq_max) ? lim_q.freq_max : speed_d;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  wire         aw_fire  = s_axi_awvalid & s_axi_awready;
  wire         w_fire   = s_axi_wvalid & s_axi_wready;
  wire         ar_fire  = s_axi_arvalid & s_axi_arready;
  wire         do_write = (aw_hold_q | aw_fire) & (w_hold_q | w_fire);
  wire         aw_hold_d = (aw_hold_q | aw_fire) & ~do_write;
  wire         w_hold_d  = (w_hold_q | w_fire) & ~do_write;
  wire         bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire         rvalid_d  = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0]   wa        = aw_fire ? s_axi_awaddr : awaddr_q;
  wire [31:0]  wd        = w_fire ? s_axi_wdata : wdata_q;
  wire [3:0]   ws        = w_fire ? s_axi_wstrb : wstrb_q;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  wire wr_ctrl  = do_write & (wa == `SRPS_OFF_CTRL);
  wire wr_lref  = do_write & (wa == `SRPS_OFF_LOCAL_REF);
  wire wr_gain  = do_write & (wa == `SRPS_OFF_GAIN);
  wire wr_lim   = do_write & (wa == `SRPS_OFF_LIMITS);
  wire wr_ramp  = do_write & (wa == `SRPS_OFF_RAMP);
  wire wr_hit   = wr_ctrl | wr_lref | wr_gain | wr_lim | wr_ramp;
  wire [31:0] ctrl_wm = wmerge(ctrl_q, wd, ws);
  wire [31:0] lref_wm = wmerge({16'h0, local_ref_q}, wd, ws);
  wire [31:0] ramp_wm = wmerge({16'h0, ramp_step_q}, wd, ws);

  // Read decode; status shows the live key mode and selection
  wire [31:0] stat_w = {freq_q, 8'h00, alarm_q, run_q, remote_q, local_q, mode_q};
  wire rd_hit = (s_axi_araddr[7:2] <= 6'h6) & (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_w =
    (s_axi_araddr == `SRPS_OFF_CTRL)      ? {20'h0, ctrl_q[11:0]} :
    (s_axi_araddr == `SRPS_OFF_LOCAL_REF) ? {16'h0, local_ref_q} :
    (s_axi_araddr == `SRPS_OFF_GAIN)      ? gain_q :
    (s_axi_araddr == `SRPS_OFF_LIMITS)    ? lim_q :
    (s_axi_araddr == `SRPS_OFF_RAMP)      ? {16'h0, ramp_step_q} :
    (s_axi_araddr == `SRPS_OFF_STATUS)    ? stat_w :
    (s_axi_araddr == `SRPS_OFF_LOOP)      ? {pid_out, fb_w} : 32'h0000_0000;

  // Bus handshake; readies drop while a response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SRPS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `SRPS_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else if (ce) begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      s_axi_awready <= ~aw_hold_d & ~bvalid_d;
      s_axi_wready  <= ~w_hold_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (aw_fire) awaddr_q <= s_axi_awaddr;
      if (w_fire) wdata_q <= s_axi_wdata;
      if (w_fire) wstrb_q <= s_axi_wstrb;
      if (do_write) s_axi_bresp <= wr_hit ? `SRPS_RESP_OKAY : `SRPS_RESP_SLVERR;
      if (ar_fire) s_axi_rdata <= rd_hit ? rd_w : 32'h0000_0000;
      if (ar_fire) s_axi_rresp <= rd_hit ? `SRPS_RESP_OKAY : `SRPS_RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Software write beats an arrow key in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= `SRPS_CTRL_RST;
      gain_q      <= `SRPS_GAIN_RST;
      lim_q       <= `SRPS_LIMITS_RST;
      ramp_step_q <= `SRPS_RAMP_RST;
      local_ref_q <= `SRPS_LOCAL_REF_RST;
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= {20'h0, ctrl_wm[11:0]};
      if (wr_gain) gain_q <= wmerge(gain_q, wd, ws);
      if (wr_lim) lim_q <= wmerge(lim_q, wd, ws);
      if (wr_ramp) ramp_step_q <= ramp_wm[15:0];
      if (wr_lref) begin
        local_ref_q <= lref_wm[15:0];
      end else if (press_up) begin
        local_ref_q <= (local_ref_q > 16'hFFFF - `SRPS_LOCAL_STEP)
                     ? 16'hFFFF : local_ref_q + `SRPS_LOCAL_STEP;
      end else if (press_down) begin
        local_ref_q <= (local_ref_q < `SRPS_LOCAL_STEP)
                     ? 16'h0000 : local_ref_q - `SRPS_LOCAL_STEP;
      end
    end
  end

  // ----------------------------------------
  // Mode, site and alarm state
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keys_prev_q <= '0;
      mode_q      <= SRPS_KM_AUTO_OFF;
      run_q       <= 1'b0;
      alarm_q     <= 1'b0;
      remote_q    <= 1'b1;
      local_q     <= 1'b0;
    end else if (ce) begin
      keys_prev_q <= keys_s;
      mode_q      <= mode_d;
      run_q       <= run_d;
      alarm_q     <= alarm_d;
      remote_q    <= remote_d;
      local_q     <= ~remote_d;
    end
  end

  // ----------------------------------------
  // Control period and loop update
  // ----------------------------------------
  // Integrator is wide; long saturation is bounded by the hold option
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_q <= 32'h0000_0000;
      tick_q    <= 1'b0;
      ti_cnt_q  <= 16'h0000;
      integ_q   <= 32'sh0;
      ramp_q    <= 16'h0000;
      speed_q   <= 16'h0000;
      freq_q    <= 16'h0000;
    end else if (ce) begin
      tick_q    <= per_cnt_q == 32'(CTRL_PERIOD_CYC - 1);
      per_cnt_q <= (per_cnt_q == 32'(CTRL_PERIOD_CYC - 1)) ? 32'h0 : per_cnt_q + 32'h1;
      if (!closed_w || !run_q) begin
        integ_q  <= 32'sh0;
        ti_cnt_q <= 16'h0000;
      end else if (integ_go) begin
        ti_cnt_q <= ti_due ? 16'h0000 : ti_cnt_q + 16'h1;
        if (ti_due) integ_q <= integ_q + 32'(err_w);
      end
      if (tick_q) begin
        ramp_q  <= ramp_d;
        speed_q <= speed_d;
        freq_q  <= freq_d;
      end
    end
  end

  assign motor_freq    = freq_q;
  assign motor_run     = run_q;
  assign remote_active = remote_q;
  assign alarm_active  = alarm_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_man_press;
    ce && press_man && !press_off;
  endsequence

  sequence s_auto_press;
    ce && press_auto && !press_off && !press_man;
  endsequence

  speed_limit_a: assert property (ce && tick_q |=> speed_q <= $past(lim_q.speed_max))
    else $error("speed above speed limit");
  freq_clamp_a: assert property (ce && tick_q |=> freq_q <= $past(lim_q.freq_max))
    else $error("frequency above frequency limit");
  closed_route_a: assert property (run_q && closed_w |-> demand_w == pid_out)
    else $error("closed loop demand not from controller");
  key_gate_a: assert property (ce && keys_s.man_start && !keys_prev_q.man_start
      && !ctrl_q.man_key_en && !press_off && !press_auto |=> $stable(mode_q))
    else $error("disabled start key changed mode");
  alarm_clear_a: assert property (ce && press_reset && !alarm_s |=> !alarm_q)
    else $error("reset key did not clear alarm");
  man_enter_a: assert property (s_man_press |=> mode_q == SRPS_KM_MAN
      ##1 ($past(ctrl_q.ref_site) != `SRPS_SITE_LINKED || !$past(ce) || !remote_q))
    else $error("manual key did not select manual mode");
  auto_enter_a: assert property (s_auto_press |=> mode_q == SRPS_KM_AUTO)
    else $error("auto key did not select auto mode");
  site_local_a: assert property (ce && ctrl_q.ref_site == `SRPS_SITE_LOCAL
      ##1 ce && ctrl_q.ref_site == `SRPS_SITE_LOCAL |-> !remote_q)
    else $error("local site yet remote reference active");
  one_active_a: assert property (remote_q != local_q)
    else $error("local and remote reference both or neither active");
  integ_off_a: assert property (ce && ti_off && closed_w && run_q |=>
      integ_q == $past(integ_q))
    else $error("integrator moved while disabled");
  windup_hold_a: assert property (ce && wind_hold && closed_w && run_q |=>
      integ_q == $past(integ_q))
    else $error("integrator moved while held");
  tick_period_a: assert property (ce && tick_q |=> !tick_q)
    else $error("control tick wider than one cycle");

endmodule : srps_top

// *** srps_params.svh ***
`ifndef SRPS_PARAMS_SVH
`define SRPS_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SRPS_OFF_CTRL      8'h00
`define SRPS_OFF_LOCAL_REF 8'h04
`define SRPS_OFF_GAIN      8'h08
`define SRPS_OFF_LIMITS    8'h0C
`define SRPS_OFF_RAMP      8'h10
`define SRPS_OFF_STATUS    8'h14
`define SRPS_OFF_LOOP      8'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRPS_CTRL_RST      32'h0000_0F20
`define SRPS_LOCAL_REF_RST 16'h0000
`define SRPS_GAIN_RST      32'h0014_0100
`define SRPS_LIMITS_RST    32'hFFFF_FFFF
`define SRPS_RAMP_RST      16'h0010

// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define SRPS_CFG_OPEN      2'h0
`define SRPS_CFG_CLOSED    2'h3
`define SRPS_SITE_LINKED   2'h0
`define SRPS_SITE_REMOTE   2'h1
`define SRPS_SITE_LOCAL    2'h2
`define SRPS_FB_AIN54      2'h0
`define SRPS_TI_OFF        16'h2710
`define SRPS_LOCAL_STEP    16'h0010
`define SRPS_KP_FRAC_BITS  8
`define SRPS_CLK_PERIOD_NS 10
`define SRPS_CTRL_PERIOD_NS 1000000
`define SRPS_RESP_OKAY     2'h0
`define SRPS_RESP_SLVERR   2'h2

`endif

// *** srps_pkg.sv ***
package srps_pkg;

  // ----------------------------------------
  // Key mode states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    SRPS_KM_MAN_OFF  = 4'b0001,
    SRPS_KM_MAN      = 4'b0010,
    SRPS_KM_AUTO     = 4'b0100,
    SRPS_KM_AUTO_OFF = 4'b1000
  } srps_mode_e;

  // Control register layout
  typedef struct packed {
    logic [19:0] rsvd;
    logic        reset_key_en;
    logic        auto_key_en;
    logic        off_key_en;
    logic        man_key_en;
    logic [1:0]  fb_sel;
    logic        integrator_hold_enable;
    logic        control_direction_select;
    logic [1:0]  ref_site;
    logic [1:0]  cfg_mode;
  } srps_ctrl_s;

  // Gain register layout
  typedef struct packed {
    logic [15:0] integral_time;
    logic [15:0] proportional_gain;
  } srps_gain_s;

  // Limit register layout
  typedef struct packed {
    logic [15:0] freq_max;
    logic [15:0] speed_max;
  } srps_limits_s;

  // Operator panel keys
  typedef struct packed {
    logic man_start;
    logic auto_start;
    logic off;
    logic reset;
    logic up;
    logic down;
  } srps_keys_s;

endpackage : srps_pkg

// *** srps_sync.sv ***
module srps_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Two stages; only the second stage is visible outside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : srps_sync

// *** srps_partner.sv ***
// ----------------------------------------
// Panel keypad and process sensors
// ----------------------------------------
module srps_partner (
  input  wire logic                 aclk,
  input  wire srps_pkg::srps_keys_s key_req,
  input  wire logic [15:0]          level,
  output srps_pkg::srps_keys_s      operator_panel,
  output logic [15:0]               fb_ain54,
  output logic [15:0]               fb_ain53,
  output logic [15:0]               fb_bus
);
  import srps_pkg::*;
  // Distinct copies per source, so a wrong feedback pick shows up
  assign fb_ain54 = level;
  assign fb_ain53 = level ^ 16'h00FF;
  assign fb_bus   = level ^ 16'hFF00;
  // Keys pass a contact register, like a real keypad scan
  always_ff @(posedge aclk) begin
    operator_panel <= key_req;
  end
endmodule : srps_partner

// *** srps_top_tb.sv ***
module srps_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import srps_pkg::*;
  // ----------------------------------------
  // Bench signals and instances
  // ----------------------------------------
  logic        aclk, aresetn, awv, wv, arv, rrun, alarm, awrdy, wrdy, arrdy, bv, rv;
  logic        mrun, ract, aact;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdata, got;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] rref, level, mfreq, fb54, fb53, fbb;
  srps_keys_s  keys, panel;
  int          err_count, check_count;

  srps_partner peer (.aclk(aclk), .key_req(keys), .level(level), .operator_panel(panel),
    .fb_ain54(fb54), .fb_ain53(fb53), .fb_bus(fbb));
  srps_top #(.CTRL_PERIOD_CYC(8)) dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .operator_panel(panel), .alarm_event(alarm), .remote_run(rrun),
    .remote_ref(rref), .fb_ain54(fb54), .fb_ain53(fb53), .fb_bus(fbb), .motor_freq(mfreq),
    .motor_run(mrun), .remote_active(ract), .alarm_active(aact));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // A stuck handshake ends the run rather than hanging it
  task automatic bound(input int n);
    if (n > 60) begin
      err_count++;
      conclude();
    end
  endtask : bound

  // Drivers start on a rising edge and end mid-cycle, so outputs read settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, tb;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ta = awv & awrdy;
      tw = wv & wrdy;
      tb = bv;
      resp = bresp;
      n++;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      bound(n);
    end while (!tb);
    repeat (2) @(negedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int   n;
    logic ta, tr;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ta = arv & arrdy;
      tr = rv;
      got = rdata;
      resp = rresp;
      n++;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      bound(n);
    end while (!tr);
    @(negedge aclk);
  endtask : rd

  // Key held long enough for sync plus the mode update
  task automatic press(input int b);
    @(posedge aclk);
    keys[b] <= 1'b1;
    repeat (6) @(posedge aclk);
    keys[b] <= 1'b0;
    repeat (6) @(negedge aclk);
  endtask : press

  task automatic t_reset();
    chk({ract, aact, mrun, mfreq}, {3'b100, 16'h0000});
    rd(8'h00);
    chk(got, 32'h0000_0F20);
    rd(8'h18);
    chk(got[15:0], 16'h0150);
    rd(8'h1C);
    chk({resp, got}, {2'h2, 32'h0});
    wr(8'h1C, 32'h0000_0000);
    chk(resp, 2'h2);
    $display("test reset done");
  endtask : t_reset

  task automatic t_site();
    press(5);
    chk(ract, 1'b0);
    press(3);
    chk(ract, 1'b0);
    press(4);
    chk(ract, 1'b1);
    press(3);
    rd(8'h14);
    chk(got[5:0], 6'b10_1000);
    wr(8'h00, 32'h0000_0E28);
    chk(ract, 1'b0);
    wr(8'h00, 32'h0000_0E24);
    chk(ract, 1'b1);
    wr(8'h00, 32'h0000_0E20);
    press(5);
    chk(ract, 1'b1);
    $display("test site done");
  endtask : t_site

  task automatic t_open();
    int n;
    wr(8'h0C, 32'h0060_0080);
    chk(resp, 2'h0);
    press(4);
    @(posedge aclk);
    rref <= 16'h0100;
    rrun <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      bound(n);
    end while (mfreq === 16'h0);
    chk(mfreq, 16'h0010);
    repeat (200) @(negedge aclk);
    chk({mrun, mfreq}, 17'h1_0060);
    wr(8'h0C, 32'h00F0_0080);
    repeat (200) @(negedge aclk);
    chk(mfreq, 16'h0080);
    $display("test open loop done");
  endtask : t_open

  // Proportional only: integrator turned off by the 10000 setting
  task automatic t_closed();
    wr(8'h00, 32'h0000_0F07);
    wr(8'h08, 32'h2710_0100);
    @(posedge aclk);
    level <= 16'h0200;
    repeat (200) @(negedge aclk);
    chk(mfreq, 16'h0000);
    wr(8'h00, 32'h0000_0F17);
    repeat (200) @(negedge aclk);
    chk(mfreq, 16'h0080);
    wr(8'h00, 32'h0000_0F57);
    rd(8'h18);
    chk(got[15:0], 16'h02FF);
    $display("test closed loop done");
  endtask : t_closed

  task automatic t_alarm();
    @(posedge aclk);
    alarm <= 1'b1;
    repeat (4) @(posedge aclk);
    alarm <= 1'b0;
    repeat (6) @(negedge aclk);
    chk({aact, mrun}, 2'b10);
    press(2);
    chk(aact, 1'b0);
    $display("test alarm done");
  endtask : t_alarm

  // Hold on, output pinned high: a wound-up integrator would keep it high after reversal
  task automatic t_integ();
    wr(8'h00, 32'h0000_0F37);
    wr(8'h08, 32'h0001_0100);
    repeat (100) @(negedge aclk);
    wr(8'h00, 32'h0000_0F27);
    rd(8'h18);
    chk(got[31:16], 16'h0000);
    $display("test integrator hold done");
  endtask : t_integ

  initial begin
    {awv, wv, arv, rrun, alarm, aresetn, awa, ara, wd, rref, keys} = '0;
    level = 16'h0150;
    err_count = 0;
    check_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset();
    t_site();
    t_open();
    t_closed();
    t_alarm();
    t_integ();
    conclude();
  end
endmodule : srps_top_tb
